/* File: ras_pkg.sv */
package ras_pkg;
	localparam int          RAS_PC_W      = 21;
	localparam int          RAS_PTR_W     = 5;
	localparam int          RAS_DEPTH     = 31;
	localparam logic [4:0]  RAS_PTR_RST   = 5'h00;
	localparam logic [4:0]  RAS_PTR_MAX   = 5'h1F;
	localparam logic [4:0]  RAS_PTR_ONE   = 5'h01;
	localparam logic [20:0] RAS_PC_ZERO   = 21'h000000;
	localparam logic [20:0] RAS_PC_STEP   = 21'h000002;
	localparam int          RAS_UPPER_LSB = 16;
	localparam int          RAS_HIGH_LSB  = 8;

	typedef struct packed {
		logic        push;
		logic        pop;
		logic [20:0] pc;
	} ras_core_req_t;

	typedef struct packed {
		logic       ptr_wr;
		logic [4:0] ptr_wdata;
		logic       full_clr;
		logic       unf_clr;
		logic       upper_wr;
		logic       high_wr;
		logic       low_wr;
		logic [7:0] wdata;
	} ras_sw_req_t;

	typedef struct packed {
		logic [4:0]  ptr;
		logic        full;
		logic        unf;
		logic        ovf_rst;
		logic [20:0] ret_pc;
		logic        ret_valid;
	} ras_state_t;
endpackage : ras_pkg

/* File: ras_entry_split.sv */
`timescale 1ns/10ps
module ras_entry_split
	import ras_pkg::*;
(
	input  wire logic [RAS_PC_W-1:0] entry,
	output logic      [7:0]          upper,
	output logic      [7:0]          high,
	output logic      [7:0]          low
);
	// unused upper bits of the upper byte read as zero
	always_comb begin
		upper = 8'h00;
		upper[RAS_PC_W-RAS_UPPER_LSB-1:0] = entry[RAS_PC_W-1:RAS_UPPER_LSB];
		high  = entry[RAS_UPPER_LSB-1:RAS_HIGH_LSB];
		low   = entry[RAS_HIGH_LSB-1:0];
	end
endmodule : ras_entry_split

/* File: ras_stack.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - push: bump pointer, then store pc
// - pop: read entry, then drop pointer
// - every reset zeroes the pointer
// - pointer zero has no storage
// - pointer 0..31, software readable and writable
// - three top bytes mirror selected entry
// - calls, relative calls, interrupts all push
// - software can push/pop via top registers
// - full flag on 31st push
// - full clears by software or power-on
// - overflow reset: store pc+2, full, reset
// - after overflow reset: full kept, pointer zero
// - no overflow reset: full, pointer to 31
// - later pushes neither overwrite nor move
// - empty pop: pc zero, underflow, pointer zero
// - underflow clears by software or power-on
// - underflow vectors without resetting registers
module ras_stack
	import ras_pkg::*;
#(
	parameter int PC_W  = RAS_PC_W,
	parameter int DEPTH = RAS_DEPTH
)
(
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          por_n,
	input  wire logic          overflow_reset_enable,
	input  wire ras_core_req_t core_req,
	input  wire ras_sw_req_t   sw_req,
	output logic [PC_W-1:0]    ret_pc,
	output logic               ret_valid,
	output logic               overflow_reset_req,
	output logic [4:0]         return_stack_pointer,
	output logic               stack_full_flag,
	output logic               stack_underflow_flag,
	output logic [7:0]         top_entry_upper,
	output logic [7:0]         top_entry_high,
	output logic [7:0]         top_entry_low
);
	initial begin
		if (PC_W != RAS_PC_W || DEPTH != RAS_DEPTH)
			$error("ras_stack: unsupported width or depth");
	end

	// the array has no entry 0: pointer zero is empty and reads as zero
	logic [PC_W-1:0] mem [1:DEPTH];
	ras_state_t      st_r;
	ras_state_t      st_nxt;
	logic [PC_W-1:0] top_entry;
	logic            mem_we;
	logic [4:0]      mem_wa;
	logic [PC_W-1:0] mem_wd;
	logic            flags_r;
	logic            full_r;
	logic            unf_r;
	logic            full_nxt;
	logic            unf_nxt;

	assign top_entry = (st_r.ptr == RAS_PTR_RST) ? RAS_PC_ZERO : mem[st_r.ptr];

	ras_entry_split u_split (
		.entry (top_entry),
		.upper (top_entry_upper),
		.high  (top_entry_high),
		.low   (top_entry_low)
	);

	always_comb begin
		st_nxt           = st_r;
		st_nxt.ret_valid = 1'b0;
		st_nxt.ovf_rst   = 1'b0;
		full_nxt         = full_r;
		unf_nxt          = unf_r;
		mem_we           = 1'b0;
		mem_wa           = st_r.ptr;
		mem_wd           = core_req.pc;
		// software writes, then hardware events; set beats clear
		if (sw_req.full_clr)
			full_nxt = 1'b0;
		if (sw_req.unf_clr)
			unf_nxt = 1'b0;
		if (sw_req.ptr_wr)
			st_nxt.ptr = sw_req.ptr_wdata;
		if (st_r.ptr != RAS_PTR_RST && (sw_req.upper_wr || sw_req.high_wr || sw_req.low_wr)) begin
			mem_we = 1'b1;
			mem_wd = top_entry;
			if (sw_req.upper_wr)
				mem_wd[PC_W-1:RAS_UPPER_LSB] = sw_req.wdata[PC_W-RAS_UPPER_LSB-1:0];
			if (sw_req.high_wr)
				mem_wd[RAS_UPPER_LSB-1:RAS_HIGH_LSB] = sw_req.wdata;
			if (sw_req.low_wr)
				mem_wd[RAS_HIGH_LSB-1:0] = sw_req.wdata;
		end
		// core push covers call, relative call and interrupt entry
		if (core_req.push) begin
			if (st_r.ptr == RAS_PTR_MAX) begin
				full_nxt = 1'b1;
			end else begin
				st_nxt.ptr = st_r.ptr + RAS_PTR_ONE;
				mem_we     = 1'b1;
				mem_wa     = st_r.ptr + RAS_PTR_ONE;
				mem_wd     = core_req.pc;
				if (st_r.ptr == RAS_PTR_MAX - RAS_PTR_ONE) begin
					full_nxt = 1'b1;
					if (overflow_reset_enable) begin
						mem_wd         = core_req.pc + RAS_PC_STEP;
						st_nxt.ptr     = RAS_PTR_RST;
						st_nxt.ovf_rst = 1'b1;
					end
				end
			end
		end else if (core_req.pop) begin
			st_nxt.ret_valid = 1'b1;
			if (st_r.ptr == RAS_PTR_RST) begin
				st_nxt.ret_pc = RAS_PC_ZERO;
				unf_nxt       = 1'b1;
			end else begin
				st_nxt.ret_pc = top_entry;
				st_nxt.ptr    = st_r.ptr - RAS_PTR_ONE;
			end
		end
	end

	// pointer and pulses clear on every reset; flags only on power-on
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.ptr       <= RAS_PTR_RST;
			st_r.ret_pc    <= RAS_PC_ZERO;
			st_r.ret_valid <= 1'b0;
			st_r.ovf_rst   <= 1'b0;
		end else begin
			st_r.ptr       <= st_nxt.ptr;
			st_r.ret_pc    <= st_nxt.ret_pc;
			st_r.ret_valid <= st_nxt.ret_valid;
			st_r.ovf_rst   <= st_nxt.ovf_rst;
		end
	end

	// flags survive the overflow reset and other non power-on resets
	always_ff @(posedge sys_clk or negedge por_n) begin
		if (!por_n) begin
			full_r  <= 1'b0;
			unf_r   <= 1'b0;
			flags_r <= 1'b0;
		end else begin
			full_r  <= full_nxt;
			unf_r   <= unf_nxt;
			flags_r <= 1'b1;
		end
	end

	assign st_r.full = full_r;
	assign st_r.unf  = unf_r;

	always_ff @(posedge sys_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign ret_pc               = st_r.ret_pc;
	assign ret_valid            = st_r.ret_valid;
	assign overflow_reset_req   = st_r.ovf_rst;
	assign return_stack_pointer = st_r.ptr;
	assign stack_full_flag      = full_r;
	assign stack_underflow_flag = unf_r;

	a_push_ptr_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_req.push && !sw_req.ptr_wr && st_r.ptr < RAS_PTR_MAX - RAS_PTR_ONE
		|=> st_r.ptr == $past(st_r.ptr) + RAS_PTR_ONE)
		else $error("push did not advance pointer");
	a_pop_ret_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_req.pop && !core_req.push && st_r.ptr != RAS_PTR_RST && !sw_req.ptr_wr
		|=> ret_valid && ret_pc == $past(top_entry) && st_r.ptr == $past(st_r.ptr) - RAS_PTR_ONE)
		else $error("pop returned wrong value or pointer");
	a_empty_pop_unf: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
		core_req.pop && !core_req.push && st_r.ptr == RAS_PTR_RST && !sw_req.ptr_wr
		|=> ret_pc == RAS_PC_ZERO && stack_underflow_flag && st_r.ptr == RAS_PTR_RST)
		else $error("empty pop mishandled");
	a_ovf_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
		core_req.push && overflow_reset_enable && st_r.ptr == RAS_PTR_MAX - RAS_PTR_ONE
		|=> overflow_reset_req && stack_full_flag && st_r.ptr == RAS_PTR_RST)
		else $error("overflow reset not raised");
	a_sat_full_ptr: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
		core_req.push && !overflow_reset_enable && st_r.ptr == RAS_PTR_MAX - RAS_PTR_ONE && !sw_req.ptr_wr
		|=> stack_full_flag && st_r.ptr == RAS_PTR_MAX)
		else $error("saturating push wrong");
	a_sat_hold_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_req.push && st_r.ptr == RAS_PTR_MAX && !sw_req.ptr_wr && !sw_req.low_wr
		&& !sw_req.high_wr && !sw_req.upper_wr
		|=> st_r.ptr == RAS_PTR_MAX && $stable(top_entry))
		else $error("push beyond full moved stack");
	a_full_sticky: assert property (@(posedge sys_clk) disable iff (!por_n)
		flags_r && $fell(stack_full_flag) |-> $past(sw_req.full_clr))
		else $error("full flag cleared without software");
	a_unf_sticky: assert property (@(posedge sys_clk) disable iff (!por_n)
		flags_r && $fell(stack_underflow_flag) |-> $past(sw_req.unf_clr))
		else $error("underflow flag cleared without software");
endmodule : ras_stack

/* File: ras_core_model.sv */
`timescale 1ns/10ps
module ras_core_model
	import ras_pkg::*;
(
	input  wire logic        sys_clk,
	output ras_core_req_t    core_req,
	input  wire logic [20:0] ret_pc,
	input  wire logic        ret_valid
);
	initial core_req = '0;
	// caller hands the pc already past the call; idle pc is inverted so a stale value never looks right
	task push(input logic [20:0] pc);
		@(posedge sys_clk);
		core_req <= '{1'b1, 1'b0, pc};
		@(posedge sys_clk);
		core_req <= '{1'b0, 1'b0, ~pc};
		#1;
	endtask : push
	task pop(output logic [20:0] got, output logic vld);
		@(posedge sys_clk);
		core_req.pop <= 1'b1;
		@(posedge sys_clk);
		core_req.pop <= 1'b0;
		#1;
		got = ret_pc;
		vld = ret_valid;
	endtask : pop
endmodule : ras_core_model

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import ras_pkg::*;
	logic          sys_clk = 0, rst_n = 0, por_n = 0, overflow_reset_enable = 1;
	ras_sw_req_t   sw_req = '0;
	ras_core_req_t core_req;
	logic [20:0]   ret_pc, got;
	logic [4:0]    return_stack_pointer;
	logic [7:0]    top_entry_upper, top_entry_high, top_entry_low;
	logic          ret_valid, overflow_reset_req, stack_full_flag, stack_underflow_flag, vld;
	int            error_cnt = 0, comparisons = 0, ovf_cnt = 0;
	wire [20:0]    top_w = {top_entry_upper[4:0], top_entry_high, top_entry_low};
	always #25 sys_clk = ~sys_clk;
	// counted one edge late, so only read after further traffic
	always @(posedge sys_clk) if (overflow_reset_req === 1'b1) ovf_cnt++;
	ras_stack dut (.sys_clk, .rst_n, .por_n, .overflow_reset_enable, .core_req, .sw_req, .ret_pc, .ret_valid,
		.overflow_reset_req, .return_stack_pointer, .stack_full_flag, .stack_underflow_flag,
		.top_entry_upper, .top_entry_high, .top_entry_low);
	ras_core_model core (.sys_clk, .core_req, .ret_pc, .ret_valid);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function ras_sw_req_t sq(logic pw, logic [4:0] p, logic fc, logic uc, logic [2:0] bw, logic [7:0] d);
		return '{pw, p, fc, uc, bw[2], bw[1], bw[0], d};
	endfunction : sq
	// no core push is issued while software owns the stack
	task sw(input ras_sw_req_t r);
		@(posedge sys_clk);
		sw_req <= r;
		@(posedge sys_clk);
		sw_req <= '0;
		#1;
	endtask : sw
	task rst(input logic por);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		por_n <= ~por;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		#1;
	endtask : rst
	task t_basic;
		chk(return_stack_pointer, 0);
		chk(top_w, 0);
		core.push(21'h012345);
		core.push(21'h1ABCDE);
		chk(return_stack_pointer, 2);
		chk(top_w, 21'h1ABCDE);
		chk(top_entry_upper, 8'h1A);
		core.pop(got, vld);
		chk(got, 21'h1ABCDE);
		chk(vld, 1);
		chk(return_stack_pointer, 1);
		core.pop(got, vld);
		chk(got, 21'h012345);
		core.pop(got, vld);
		chk(got, 0);
		chk(vld, 1);
		chk(stack_underflow_flag, 1);
		chk(return_stack_pointer, 0);
		core.push(21'h000100);
		chk(stack_underflow_flag, 1);
		chk(ovf_cnt, 0);
		rst(1'b0);
		chk(stack_underflow_flag, 1);
		sw(sq(0, 0, 0, 1, 3'b000, 0));
		chk(stack_underflow_flag, 0);
	endtask : t_basic
	task t_sw;
		sw(sq(1, 5'h03, 0, 0, 3'b000, 0));
		chk(return_stack_pointer, 3);
		sw(sq(0, 0, 0, 0, 3'b111, 8'hA5));
		chk(top_w, 21'h05A5A5);
		chk(top_entry_upper, 8'h05);
		core.pop(got, vld);
		chk(got, 21'h05A5A5);
		sw(sq(1, 5'h1F, 0, 0, 3'b000, 0));
		chk(return_stack_pointer, 31);
		sw(sq(1, 5'h00, 0, 0, 3'b000, 0));
		sw(sq(0, 0, 0, 0, 3'b001, 8'h77));
		chk(top_w, 0);
	endtask : t_sw
	task t_full;
		overflow_reset_enable <= 1'b0;
		for (int i = 1; i <= 31; i++) begin
			if (i == 31) chk(stack_full_flag, 0);
			core.push(21'(i * 3));
		end
		chk(stack_full_flag, 1);
		chk(return_stack_pointer, 31);
		core.push(21'h1FFFFF);
		chk(return_stack_pointer, 31);
		chk(top_w, 21'd93);
		chk(ovf_cnt, 0);
		core.pop(got, vld);
		chk(stack_full_flag, 1);
		rst(1'b0);
		chk(stack_full_flag, 1);
		chk(return_stack_pointer, 0);
		sw(sq(0, 0, 1, 0, 3'b000, 0));
		chk(stack_full_flag, 0);
	endtask : t_full
	task t_ovf;
		overflow_reset_enable <= 1'b1;
		sw(sq(1, 5'h1E, 0, 0, 3'b000, 0));
		core.push(21'h000400);
		chk(overflow_reset_req, 1);
		chk(stack_full_flag, 1);
		chk(return_stack_pointer, 0);
		rst(1'b0);
		chk(stack_full_flag, 1);
		sw(sq(1, 5'h1F, 0, 0, 3'b000, 0));
		chk(top_w, 21'h000402);
		chk(ovf_cnt, 1);
	endtask : t_ovf
	task results;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		#1;
		t_basic;
		t_sw;
		t_full;
		t_ovf;
		results;
	end
	// whole run is about 110 cycles; the 1000-cycle limit is ample margin
	initial begin
		#50000;
		error_cnt++;
		results;
	end
endmodule : tb_top
